// ### vtrm_pkg.sv
// constants and carrier types of the velocity and torque ramp block
// assumes one system clock; all mode codes are used by vtrm_ramp, SW_REACHED and SW_LIMIT are not
package vtrm_pkg;
   localparam logic [7:0] MODE_VL = 8'h02; // plain velocity
   localparam logic [7:0] MODE_PV = 8'h03; // profile velocity
   localparam logic [7:0] MODE_TQ = 8'h04; // profile torque
   localparam int CW_HALT = 8; // halt bit of the control word
   localparam int SW_REACHED = 10; // target reached status bit
   localparam int SW_LIMIT = 11; // internal limit active status bit
   localparam int POL_SPEED = 6; // speed sign inversion bit of polarity
   localparam logic [7:0] RAMP_TRAP = 8'h00; // trapezoidal ramp
   localparam logic [7:0] RAMP_JERK = 8'h03; // jerk-limited ramp
   localparam logic [31:0] UNIT_ONE = 32'h0000_0001; // factor value meaning rpm
   localparam logic [31:0] SEC_PER_MIN = 32'h0000_003C; // rps to rpm
   localparam int PERMILLE = 1000; // torque full scale in thousandths
   // speed change over time in seconds
   typedef struct packed {
      logic [31:0] dv; // speed change, positive
      logic [31:0] dt; // time in seconds
   } vtrm_slope_s;
   // outgoing status
   typedef struct packed {
      logic reached; // status bit 10
      logic limit; // status bit 11
   } vtrm_stat_s;
endpackage

// ### vtrm_ramp.sv
// velocity / profile velocity / profile torque set-point ramp and status
// assumes all inputs come from logic on clk; tick is a one-cycle control enable
// Operation
// - factors both one mean speeds in rpm
// - else user unit is rps times mult/div
// - selector picks electrical or mechanical revolutions unless both factors are one
// - velocity slope is speed change over seconds
// - velocity target below minimum raised to minimum
// - velocity target above maximum clamped to maximum
// - quick-stop ramp uses own change/time pair
// - ramp tracks target; limit bit while limiting
// - mode 3 profile velocity, 4 profile torque
// - profile velocity halt stops, release ramps up
// - profile velocity bit 10 with halt state
// - speed reached after full window time inside
// - polarity bit 6 inverts target speed
// - ramp type 0 trapezoid, 3 jerk limited
// - velocity demand readable and fed to controller
// - enabled profile velocity accelerates within limits
// - profile acc, dec, quick-stop set slopes
// - profile torque halt stops, release restarts
// - torque reached after window time inside
// - torque mode bit 10 with halt state
// - torque limit bit when target exceeds positive maximum
// - mode 2 selects plain velocity
// - velocity halt brakes, release accelerates
// - torque values in thousandths of rated maximum
`timescale 1ns/1ps
`default_nettype none
module vtrm_ramp #(
   parameter int TICK_HZ = 1000, // control tick rate in hertz
   parameter int TICKS_PER_MS = 1, // ticks in one window-time unit
   parameter int POLE_PAIRS = 1, // electrical revolutions per mechanical
   parameter int RATED_MA = 1000 // rated current in milliamps
) (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic tick, // control tick enable
   input wire logic [7:0] mode_sel, // mode of operation
   input wire logic op_enable, // operation enabled
   input wire logic quick_stop, // quick stop active
   input wire logic [15:0] ctrl_word, // control word
   input wire logic [7:0] polarity, // polarity setting
   input wire logic [31:0] dim_mult, // speed factor multiplier
   input wire logic [31:0] dim_div, // speed factor divisor
   input wire logic rev_mech, // 1 mechanical, 0 electrical revolutions
   input wire logic signed [31:0] vl_target, // velocity mode target
   input wire logic [31:0] vl_min, // velocity minimum amount
   input wire logic [31:0] vl_max, // velocity maximum amount
   input wire vtrm_pkg::vtrm_slope_s vl_acc, // velocity acceleration
   input wire vtrm_pkg::vtrm_slope_s vl_dec, // velocity deceleration
   input wire vtrm_pkg::vtrm_slope_s vl_qs, // velocity quick stop
   input wire logic signed [31:0] pv_target, // profile velocity target
   input wire logic [31:0] prof_acc, // profile acceleration per second
   input wire logic [31:0] prof_dec, // profile deceleration per second
   input wire logic [31:0] qs_dec, // quick-stop deceleration per second
   input wire logic [7:0] ramp_type, // motion profile type
   input wire logic [31:0] jerk, // jerk limit per second
   input wire logic [31:0] vel_window, // velocity window
   input wire logic [15:0] vel_win_time, // velocity window time
   input wire logic signed [31:0] vel_actual, // actual speed
   input wire logic signed [15:0] tq_target, // target torque, per mille
   input wire logic [15:0] tq_max, // max torque, per mille
   input wire logic [31:0] tq_slope, // torque slope per second
   input wire logic signed [15:0] tq_actual, // actual torque, per mille
   input wire logic [15:0] tq_window, // torque window
   input wire logic [15:0] tq_win_time, // torque window time
   output logic signed [31:0] vel_demand, // ramp output, user units
   output logic signed [31:0] spd_setpoint, // speed controller set-point, rpm
   output logic signed [15:0] tq_demand, // torque ramp output, per mille
   output logic signed [31:0] cur_setpoint, // current set-point, milliamps
   output vtrm_pkg::vtrm_stat_s status // status bits 10 and 11
);
   import vtrm_pkg::*;

   logic halt; // halt control bit
   logic is_vl, is_pv, is_tq; // decoded modes
   logic signed [31:0] pol_tgt; // target after polarity
   logic [31:0] tgt_mag; // target magnitude
   logic [31:0] clamp_mag; // clamped magnitude
   logic clamp_hit; // min or max clamp in effect
   logic signed [31:0] eff_tgt; // speed target used by the ramp
   logic accel; // moving away from standstill
   logic [31:0] num; // slope numerator
   logic [63:0] den; // slope denominator in ticks
   logic [31:0] jerk_rate; // jerk-limited numerator
   logic [31:0] num_used; // numerator after jerk limit
   logic [63:0] frac, next_frac; // speed fraction accumulator
   logic [63:0] step; // speed step this tick
   logic signed [32:0] diff; // target minus demand
   logic [32:0] diff_mag; // its magnitude
   logic signed [15:0] tq_eff; // torque target used by ramp
   logic [63:0] tq_frac, next_tq_frac; // torque fraction accumulator
   logic [63:0] tq_step; // torque step this tick
   logic signed [16:0] tq_diff; // torque target minus demand
   logic [16:0] tq_diff_mag; // its magnitude
   logic vel_in_win, tq_in_win; // inside tolerance windows
   logic [15:0] vel_cnt, tq_cnt; // window-time counters
   logic vel_reached, tq_reached; // window time completed
   logic zero_speed; // axis at standstill

   assign halt = ctrl_word[CW_HALT];
   // mode decode
   assign is_vl = (mode_sel == MODE_VL);
   assign is_pv = (mode_sel == MODE_PV);
   assign is_tq = (mode_sel == MODE_TQ);

   // target selection, polarity and clamping
   always_comb begin
      pol_tgt = is_vl ? vl_target : pv_target;
      if (polarity[POL_SPEED]) begin
         pol_tgt = -pol_tgt;
      end
      tgt_mag = pol_tgt[31] ? 32'(-pol_tgt) : 32'(pol_tgt);
      clamp_mag = tgt_mag;
      clamp_hit = 1'b0;
      if (is_vl && tgt_mag < vl_min) begin
         clamp_mag = vl_min;
         clamp_hit = 1'b1;
      end else if (is_vl && tgt_mag > vl_max) begin
         clamp_mag = vl_max;
         clamp_hit = 1'b1;
      end
      // halt, quick stop or no enable means standstill
      if (!op_enable || halt || quick_stop || !(is_vl || is_pv)) begin
         eff_tgt = '0;
      end else begin
         eff_tgt = pol_tgt[31] ? -$signed(clamp_mag) : $signed(clamp_mag);
      end
   end

   // slope selection
   always_comb begin
      accel = (eff_tgt > vel_demand && vel_demand >= 0) ||
              (eff_tgt < vel_demand && vel_demand <= 0);
      if (is_vl) begin
         // velocity slopes are change over seconds
         if (quick_stop) begin
            num = vl_qs.dv;
            den = 64'(vl_qs.dt) * 64'(TICK_HZ);
         end else if (accel) begin
            num = vl_acc.dv;
            den = 64'(vl_acc.dt) * 64'(TICK_HZ);
         end else begin
            num = vl_dec.dv;
            den = 64'(vl_dec.dt) * 64'(TICK_HZ);
         end
      end else begin
         // profile slopes are per second
         num = quick_stop ? qs_dec : (accel ? prof_acc : prof_dec);
         den = 64'(TICK_HZ);
      end
      // jerk limits only for profile velocity with jerk ramp
      num_used = (is_pv && ramp_type == RAMP_JERK && jerk_rate < num) ? jerk_rate : num;
      next_frac = frac + 64'(num_used);
      step = (den == '0) ? 64'hFFFF_FFFF : next_frac / den;
      diff = 33'(eff_tgt) - 33'(vel_demand);
      diff_mag = diff[32] ? 33'(-diff) : 33'(diff);
   end

   // speed ramp generator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vel_demand <= '0;
         frac <= '0;
      end else if (tick) begin
         if (64'(diff_mag) <= step) begin
            vel_demand <= eff_tgt;
            frac <= '0;
         end else begin
            frac <= (den == '0) ? '0 : next_frac % den;
            vel_demand <= diff[32] ? vel_demand - 32'(step) : vel_demand + 32'(step);
         end
      end
   end

   // jerk-limited growth of the slope, restarts at each plateau
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         jerk_rate <= '0;
      end else if (tick) begin
         if (diff_mag == '0) begin
            jerk_rate <= '0;
         end else if (jerk_rate < num) begin
            jerk_rate <= jerk_rate + ((jerk / 32'(TICK_HZ) == '0) ? 32'h1 :
                                      jerk / 32'(TICK_HZ));
         end
      end
   end

   // unit conversion of the demand for the speed controller
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         spd_setpoint <= '0;
      end else if (dim_mult == UNIT_ONE && dim_div == UNIT_ONE) begin
         spd_setpoint <= vel_demand;
      end else if (dim_mult != '0) begin
         // user = rps * mult / div, so rpm = user * div * 60 / mult
         // electrical revolutions are pole pairs times mechanical ones
         spd_setpoint <= 32'(64'(signed'(vel_demand)) * signed'(64'(dim_div)) *
                             signed'(64'(SEC_PER_MIN)) /
                             (signed'(64'(dim_mult)) *
                              (rev_mech ? 64'sh1 : signed'(64'(POLE_PAIRS)))));
      end
   end

   // torque ramp target and step
   always_comb begin
      if (!op_enable || halt || quick_stop || !is_tq) begin
         tq_eff = '0;
      end else if (tq_target > $signed(tq_max)) begin
         tq_eff = $signed(tq_max);
      end else if (tq_target < -$signed(tq_max)) begin
         tq_eff = -$signed(tq_max);
      end else begin
         tq_eff = tq_target;
      end
      next_tq_frac = tq_frac + 64'(tq_slope);
      tq_step = next_tq_frac / 64'(TICK_HZ);
      tq_diff = 17'(tq_eff) - 17'(tq_demand);
      tq_diff_mag = tq_diff[16] ? 17'(-tq_diff) : 17'(tq_diff);
   end

   // torque ramp generator
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tq_demand <= '0;
         tq_frac <= '0;
      end else if (tick) begin
         if (64'(tq_diff_mag) <= tq_step) begin
            tq_demand <= tq_eff;
            tq_frac <= '0;
         end else begin
            tq_frac <= next_tq_frac % 64'(TICK_HZ);
            tq_demand <= tq_diff[16] ? tq_demand - 16'(tq_step) : tq_demand + 16'(tq_step);
         end
      end
   end

   // per mille of rated current to milliamps
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_setpoint <= '0;
      end else begin
         cur_setpoint <= 32'(32'(tq_demand) * signed'(RATED_MA) / signed'(PERMILLE));
      end
   end

   // window checks against the demanded values
   assign vel_in_win = ((vel_actual >= vel_demand) ? 33'(vel_actual) - 33'(vel_demand) :
                        33'(vel_demand) - 33'(vel_actual)) <= 33'(vel_window);
   assign tq_in_win = ((tq_actual >= tq_demand) ? 17'(tq_actual) - 17'(tq_demand) :
                       17'(tq_demand) - 17'(tq_actual)) <= 17'(tq_window);
   assign zero_speed = (vel_demand == '0) && vel_reached;

   // velocity window-time counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vel_cnt <= '0;
         vel_reached <= 1'b0;
      end else if (!vel_in_win || vel_demand != eff_tgt) begin
         vel_cnt <= '0;
         vel_reached <= 1'b0;
      end else if (tick) begin
         if (32'(vel_cnt) >= 32'(vel_win_time) * 32'(TICKS_PER_MS)) begin
            vel_reached <= 1'b1;
         end else begin
            vel_cnt <= vel_cnt + 16'h1;
         end
      end
   end

   // torque window-time counter
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tq_cnt <= '0;
         tq_reached <= 1'b0;
      end else if (!tq_in_win || tq_demand != tq_eff) begin
         tq_cnt <= '0;
         tq_reached <= 1'b0;
      end else if (tick) begin
         if (32'(tq_cnt) >= 32'(tq_win_time) * 32'(TICKS_PER_MS)) begin
            tq_reached <= 1'b1;
         end else begin
            tq_cnt <= tq_cnt + 16'h1;
         end
      end
   end

   // status bits
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         status <= '0;
      end else if (is_tq) begin
         status.reached <= halt ? zero_speed : tq_reached;
         status.limit <= tq_target > $signed(tq_max);
      end else if (is_vl || is_pv) begin
         status.reached <= halt ? zero_speed : vel_reached;
         status.limit <= clamp_hit || (vel_demand != eff_tgt);
      end else begin
         status <= '0;
      end
   end

   // assertions
   property p_rpm_unit;
      @(posedge clk) disable iff (!rst_b)
      (dim_mult == UNIT_ONE && dim_div == UNIT_ONE) |=> spd_setpoint == $past(vel_demand);
   endproperty
   a_rpm_unit: assert property (p_rpm_unit) else $error("rpm set-point differs from demand");
   property p_min_clamp;
      @(posedge clk) disable iff (!rst_b)
      (is_vl && tgt_mag < vl_min) |-> clamp_mag == vl_min && clamp_hit;
   endproperty
   a_min_clamp: assert property (p_min_clamp) else $error("minimum speed clamp missing");
   property p_max_clamp;
      @(posedge clk) disable iff (!rst_b)
      (is_vl && tgt_mag > vl_max && vl_max >= vl_min) |-> clamp_mag == vl_max;
   endproperty
   a_max_clamp: assert property (p_max_clamp) else $error("maximum speed clamp missing");
   property p_limit_bit;
      @(posedge clk) disable iff (!rst_b)
      ((is_vl || is_pv) && clamp_hit) |=> status.limit;
   endproperty
   a_limit_bit: assert property (p_limit_bit) else $error("limit bit not set while clamping");
   property p_halt_no_grow;
      @(posedge clk) disable iff (!rst_b)
      (is_pv && halt && tick && vel_demand >= 0) |=> vel_demand <= $past(vel_demand);
   endproperty
   a_halt_no_grow: assert property (p_halt_no_grow) else $error("speed grew during halt");
   property p_win_restart;
      @(posedge clk) disable iff (!rst_b)
      !vel_in_win |=> vel_cnt == '0 && !vel_reached;
   endproperty
   a_win_restart: assert property (p_win_restart) else $error("window counter not restarted");
   property p_pv_status;
      @(posedge clk) disable iff (!rst_b)
      (is_pv && !halt) |=> status.reached == $past(vel_reached);
   endproperty
   a_pv_status: assert property (p_pv_status) else $error("bit 10 wrong in profile velocity");
   property p_tq_status;
      @(posedge clk) disable iff (!rst_b)
      (is_tq && !halt) |=> status.reached == $past(tq_reached);
   endproperty
   a_tq_status: assert property (p_tq_status) else $error("bit 10 wrong in torque mode");
   property p_tq_limit;
      @(posedge clk) disable iff (!rst_b)
      (is_tq && tq_target > $signed(tq_max)) |=> status.limit;
   endproperty
   a_tq_limit: assert property (p_tq_limit) else $error("torque limit bit missing");
   property p_polarity;
      @(posedge clk) disable iff (!rst_b)
      (is_pv && polarity[POL_SPEED]) |-> pol_tgt == -pv_target;
   endproperty
   a_polarity: assert property (p_polarity) else $error("polarity inversion missing");
   c_pv_reached: cover property (@(posedge clk) disable iff (!rst_b)
      is_pv ##1 $rose(status.reached));
   c_tq_reached: cover property (@(posedge clk) disable iff (!rst_b)
      is_tq ##1 $rose(status.reached));
   c_vl_halt: cover property (@(posedge clk) disable iff (!rst_b)
      is_vl && $rose(halt));
endmodule
`default_nettype wire

// ### vtrm_plant.sv
// far-side model: speed and torque loops that follow the demands
// assumes the demands come from registers on clk; vel_off lets the bench push speed off
`timescale 1ns/1ps
`default_nettype none
module vtrm_plant (
   input wire logic clk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic signed [31:0] vel_demand, // speed set-point from the ramp
   input wire logic signed [15:0] tq_demand, // torque set-point from the ramp
   input wire logic signed [31:0] vel_off, // speed error injected by the bench
   output logic signed [31:0] vel_actual, // measured speed
   output logic signed [15:0] tq_actual // measured torque
);
   // speed loop settles on the demand one clock later
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         vel_actual <= 32'sh0;
      end else begin
         vel_actual <= vel_demand + vel_off;
      end
   end
   // torque loop follows the torque demand
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tq_actual <= 16'sh0;
      end else begin
         tq_actual <= tq_demand;
      end
   end
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the speed and torque ramp block
// assumes vtrm_pkg and vtrm_ramp are compiled first; the plant model closes the loop
`timescale 1ns/1ps
`default_nettype none
module tb;
   import vtrm_pkg::*;
   // one table row: mode and targets beside the demand they should give
   typedef struct packed {
      logic [7:0] mode; // mode of operation
      logic [31:0] vl_t; // velocity mode target
      logic [31:0] pv_t; // profile velocity target
      logic [7:0] pol; // polarity setting
      logic [31:0] exp_v; // expected demand
      logic exp_l; // expected limit flag
      logic chk_l; // limit flag is checked
   } vtrm_row_s;
   logic clk, rst_b, tick, op_enable, quick_stop, rev_mech;
   logic [7:0] mode_sel, polarity, ramp_type;
   logic [15:0] ctrl_word, vel_win_time, tq_max, tq_window, tq_win_time;
   logic [31:0] dim_mult, dim_div, vl_min, vl_max, prof_acc, prof_dec, qs_dec, jerk;
   logic [31:0] vel_window, tq_slope;
   logic signed [31:0] vl_target, pv_target, vel_actual, vel_off;
   logic signed [31:0] vel_demand, spd_setpoint, cur_setpoint;
   logic signed [15:0] tq_target, tq_actual, tq_demand;
   vtrm_slope_s vl_acc, vl_dec, vl_qs;
   vtrm_stat_s status;
   int n_mismatch, compares;
   vtrm_row_s rows [6];
   vtrm_ramp #(.TICK_HZ(1000), .TICKS_PER_MS(1), .POLE_PAIRS(2), .RATED_MA(1000)) DUT (
      .clk(clk), .rst_b(rst_b), .tick(tick), .mode_sel(mode_sel), .op_enable(op_enable),
      .quick_stop(quick_stop), .ctrl_word(ctrl_word), .polarity(polarity),
      .dim_mult(dim_mult), .dim_div(dim_div), .rev_mech(rev_mech), .vl_target(vl_target),
      .vl_min(vl_min), .vl_max(vl_max), .vl_acc(vl_acc), .vl_dec(vl_dec), .vl_qs(vl_qs),
      .pv_target(pv_target), .prof_acc(prof_acc), .prof_dec(prof_dec), .qs_dec(qs_dec),
      .ramp_type(ramp_type), .jerk(jerk), .vel_window(vel_window),
      .vel_win_time(vel_win_time), .vel_actual(vel_actual), .tq_target(tq_target),
      .tq_max(tq_max), .tq_slope(tq_slope), .tq_actual(tq_actual), .tq_window(tq_window),
      .tq_win_time(tq_win_time), .vel_demand(vel_demand), .spd_setpoint(spd_setpoint),
      .tq_demand(tq_demand), .cur_setpoint(cur_setpoint), .status(status));
   vtrm_plant plant (.clk(clk), .rst_b(rst_b), .vel_demand(vel_demand),
      .tq_demand(tq_demand), .vel_off(vel_off), .vel_actual(vel_actual),
      .tq_actual(tq_actual));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // prints the counts and the verdict, then stops
   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // compares a 32-bit value
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   // compares a status flag
   task automatic chk1(input logic got, input logic exp, input string what);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask
   // n control ticks, each followed by settling clocks so all outputs land
   task automatic ticks(input int n);
      repeat (n) begin
         @(negedge clk) tick = 1'b1;
         @(negedge clk) tick = 1'b0;
         repeat (3) @(negedge clk);
      end
   endtask
   // watchdog sized well above the expected run of a few hundred clocks
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial begin
      n_mismatch = 0;
      compares = 0;
      {rst_b, tick, quick_stop, rev_mech, ctrl_word, polarity, ramp_type} = '0;
      op_enable = 1'b1;
      mode_sel = MODE_PV;
      dim_mult = UNIT_ONE;
      dim_div = UNIT_ONE;
      {vl_target, pv_target, vel_off, tq_target, jerk} = '0;
      vl_min = 32'h0000_0064;
      vl_max = 32'h0000_03E8;
      vl_acc = {32'h000F_4240, 32'h0000_0001}; // 1000 per tick
      vl_dec = vl_acc; // positive speed change
      vl_qs = vl_acc;
      prof_acc = 32'h000F_4240;
      prof_dec = 32'h000F_4240;
      qs_dec = 32'h000F_4240;
      vel_window = 32'h0000_0005;
      vel_win_time = 16'h0000;
      tq_max = 16'h01F4;
      tq_slope = 32'h000F_4240;
      tq_window = 16'h0005;
      tq_win_time = 16'h0000;
      rows[0] = {MODE_PV, 32'h0, 32'h64, 8'h00, 32'h64, 1'b0, 1'b1};
      rows[1] = {MODE_PV, 32'h0, 32'h64, 8'h40, 32'hFFFF_FF9C, 1'b0, 1'b1};
      rows[2] = {MODE_VL, 32'h32, 32'h0, 8'h00, 32'h64, 1'b1, 1'b1};
      rows[3] = {MODE_VL, 32'h1388, 32'h0, 8'h00, 32'h3E8, 1'b1, 1'b1};
      rows[4] = {MODE_VL, 32'h1F4, 32'h0, 8'h00, 32'h1F4, 1'b0, 1'b1};
      rows[5] = {8'h05, 32'h1F4, 32'h0, 8'h00, 32'h0, 1'b0, 1'b0};
      repeat (20) @(negedge clk);
      chk32(vel_demand, 32'h0, "demand in reset");
      rst_b = 1'b1;
      @(negedge clk);
      chk32(spd_setpoint, 32'h0, "set-point after reset");
      $display("test reset done");
      // ordinary cases: modes, clamps, polarity, rpm pass-through
      foreach (rows[i]) begin
         @(negedge clk);
         mode_sel = rows[i].mode;
         vl_target = rows[i].vl_t;
         pv_target = rows[i].pv_t;
         polarity = rows[i].pol;
         ticks(3);
         chk32(vel_demand, rows[i].exp_v, "table demand");
         chk32(spd_setpoint, rows[i].exp_v, "table rpm");
         if (rows[i].chk_l) begin
            chk1(status.limit, rows[i].exp_l, "table limit");
         end
      end
      $display("test table done");
      // slow velocity ramp of 1 per tick with a user unit of half rpm-per-60
      vl_acc = {32'h0000_03E8, 32'h0000_0001};
      mode_sel = MODE_VL;
      vl_target = 32'h0000_006E;
      dim_mult = 32'h0000_0002;
      rev_mech = 1'b1;
      ticks(3);
      chk32(vel_demand, 32'h3, "slow ramp");
      chk1(status.limit, 1'b1, "limit while ramping");
      chk32(spd_setpoint, 32'h5A, "user unit scaling");
      // electrical revolutions with two pole pairs halve the rpm
      rev_mech = 1'b0;
      repeat (2) @(negedge clk);
      chk32(spd_setpoint, 32'h2D, "electrical revolutions");
      dim_mult = UNIT_ONE;
      vl_acc = {32'h000F_4240, 32'h0000_0001};
      $display("test slope done");
      // window time: leaving the window restarts the count
      mode_sel = MODE_PV;
      pv_target = 32'h0000_0064;
      vel_win_time = 16'h0003;
      ticks(2);
      vel_off = 32'sh32;
      ticks(2);
      chk1(status.reached, 1'b0, "out of window");
      vel_off = 32'sh0;
      ticks(3);
      chk1(status.reached, 1'b0, "window time not over");
      ticks(1);
      chk1(status.reached, 1'b1, "window time over");
      $display("test window done");
      // halt: braking, standstill, restart
      vel_win_time = 16'h0000;
      prof_dec = 32'h0000_2710;
      ctrl_word = 16'h0100;
      ticks(1);
      chk32(vel_demand, 32'h5A, "halt brakes on dec");
      chk1(status.reached, 1'b0, "axis braking");
      prof_dec = 32'h000F_4240;
      ticks(2);
      chk32(vel_demand, 32'h0, "halted");
      chk1(status.reached, 1'b1, "axis at zero");
      ctrl_word = 16'h0000;
      ticks(2);
      chk32(vel_demand, 32'h64, "halt release");
      quick_stop = 1'b1;
      qs_dec = 32'h0000_2710;
      ticks(1);
      chk32(vel_demand, 32'h5A, "quick stop slope");
      quick_stop = 1'b0;
      $display("test halt done");
      // torque mode: clamp, limit flag, current scaling, reached
      mode_sel = MODE_TQ;
      tq_target = 16'sh258;
      ticks(2);
      chk32(32'(tq_demand), 32'h1F4, "torque clamped");
      chk1(status.limit, 1'b1, "torque over maximum");
      chk32(cur_setpoint, 32'h1F4, "current set-point");
      chk1(status.reached, 1'b1, "torque reached");
      tq_target = -16'sh12C;
      ticks(2);
      chk32(cur_setpoint, 32'hFFFF_FED4, "negative torque");
      chk1(status.limit, 1'b0, "torque in range");
      $display("test torque done");
      // jerk-limited start: slope grows 1000 per tick from zero, giving 0, 1, 2
      mode_sel = MODE_PV;
      pv_target = 32'h0000_0064;
      ramp_type = RAMP_JERK;
      jerk = 32'h000F_4240;
      ticks(3);
      chk32(vel_demand, 32'h3, "jerk-limited ramp");
      ramp_type = RAMP_TRAP;
      $display("test jerk done");
      // reset in mid-run clears the demands
      @(negedge clk) rst_b = 1'b0;
      @(negedge clk);
      chk32(32'(tq_demand), 32'h0, "torque in reset");
      chk32(vel_demand, 32'h0, "speed in reset");
      $display("test second reset done");
      close_out();
   end
endmodule
`default_nettype wire
